/* File: hdl/srs_map.svh */
`ifndef SRS_MAP_SVH
`define SRS_MAP_SVH
// ----------------------------------------------------------------------
// register offsets (byte addresses on the register port)
// ----------------------------------------------------------------------
`define SRS_SR_OFFSET 4'h4
`define SRS_MR_OFFSET 4'h8
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SRS_MR_UEN_BIT 0
`define SRS_MR_IRQ_BIT 4
`define SRS_MR_LEN_LSB 8
`define SRS_SR_SEEN_BIT 0
`define SRS_SR_CAUSE_LSB 8
`define SRS_SR_LEVEL_BIT 16
// ----------------------------------------------------------------------
// reset values and timing counts (slow clock cycles)
// ----------------------------------------------------------------------
`define SRS_MR_RESET_LEN 4'h0
`define SRS_STARTUP_CYCLES 2048
`define SRS_CPU_START_CYCLES 16'h0003
`define SRS_BOOT_DELAY 2'h3
`define SRS_OWN_MASK_DEPTH 3
`endif

/* File: hdl/srs_pin_if.sv */
`timescale 1ns/10ps
// link between the state machine and the pin manager
interface srs_pin_if;
    logic pulse_start;
    logic [3:0] pulse_len;
    logic hold;
    logic bk_ok;
    logic core_ok;
    logic pin_lvl;
    logic pin_fall;
    logic boot_lvl;
    logic drive_act;
    logic own_recent;
    modport mgr (
        input pulse_start, pulse_len, hold,
        output bk_ok, core_ok, pin_lvl, pin_fall, boot_lvl, drive_act, own_recent
    );
    modport seq (
        output pulse_start, pulse_len, hold,
        input bk_ok, core_ok, pin_lvl, pin_fall, boot_lvl, drive_act, own_recent
    );
endinterface : srs_pin_if

/* File: hdl/srs_pin_manager.sv */
`timescale 1ns/10ps
`include "srs_map.svh"
module srs_pin_manager
    import srs_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic backup_por_n_in,
    input wire logic core_por_n_in,
    input wire logic pin_reset_in,
    input wire logic boot_select_pin_in,
    srs_pin_if.mgr bus
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // pulse length is 2^(len+1) cycles
    function automatic logic [16:0] pulse_cycles(input logic [3:0] len);
        pulse_cycles = 17'h00001 << (5'(len) + 5'h01);
    endfunction : pulse_cycles

    srs_pin_state_t r;
    srs_pin_state_t n;
    logic [1:0] bk_s;
    logic [1:0] core_s;

    // ------------------------------------------------------------------
    // supply monitors
    // ------------------------------------------------------------------
    // assert at once on a falling supply, release through two flops
    always_ff @(posedge clk_in or negedge rst_n_in or negedge backup_por_n_in) begin
        if (!rst_n_in || !backup_por_n_in) begin
            bk_s <= 2'b00;
        end else if (clk_en_in) begin
            bk_s <= {bk_s[0], 1'b1};
        end
    end
    // core monitor drops in step with the cell output
    always_ff @(posedge clk_in or negedge rst_n_in or negedge core_por_n_in) begin
        if (!rst_n_in || !core_por_n_in) begin
            core_s <= 2'b00;
        end else if (clk_en_in) begin
            core_s <= {core_s[0], 1'b1};
        end
    end

    // ------------------------------------------------------------------
    // pin sampling and pulse shaping
    // ------------------------------------------------------------------
    always_comb begin
        n = r;
        n.pin_meta = pin_reset_in;
        n.pin_lvl = r.pin_meta;
        n.pin_lvl_d = r.pin_lvl;
        n.boot_meta = boot_select_pin_in;
        n.boot_lvl = r.boot_meta;
        // the start cycle drives on its own, so the counter covers the rest
        if (bus.pulse_start) begin
            n.cnt = pulse_cycles(bus.pulse_len) - 17'h1;
        end else if (r.cnt != 17'h0) begin
            n.cnt = r.cnt - 17'h1;
        end
        // own drive is seen late through the synchroniser, mask it a while
        n.recent = {r.recent[1:0], bus.drive_act};
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r <= '{pin_meta: 1'b1, pin_lvl: 1'b1, pin_lvl_d: 1'b1, default: '0};
        end else if (clk_en_in) begin
            r <= n;
        end
    end

    assign bus.bk_ok = bk_s[1];
    assign bus.core_ok = core_s[1];
    assign bus.pin_lvl = r.pin_lvl;
    assign bus.pin_fall = r.pin_lvl_d & ~r.pin_lvl;
    assign bus.boot_lvl = r.boot_lvl;
    // start strobe keeps the line low across the hand-over from the hold term
    assign bus.drive_act = bus.hold | bus.pulse_start | (r.cnt != 17'h0) | ~bk_s[1];
    assign bus.own_recent = bus.drive_act | (|r.recent);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_pulse_min_two: assert property (@(posedge clk_in) disable iff (!rst_n_in || !clk_en_in)
        bus.pulse_start |-> bus.drive_act [*2])
        else $error("pin pulse shorter than two cycles");
    a_pulse_len_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in || !clk_en_in)
        bus.pulse_start && bus.pulse_len == 4'h0 |=> r.cnt == 17'h1)
        else $error("zero length field did not load two cycles");
endmodule : srs_pin_manager

/* File: hdl/srs_pkg.sv */
package srs_pkg;
    // sequencer states
    typedef enum logic [2:0] {
        ST_BK_START, ST_BK_CLK3, ST_RUN, ST_CORE_DOWN, ST_WAKE3, ST_USER, ST_USER3
    } srs_state_t;
    // reset cause codes
    typedef enum logic [2:0] {
        CAUSE_GENERAL = 3'h0, CAUSE_WAKE = 3'h1, CAUSE_USER = 3'h4
    } srs_cause_t;
    // pin manager state
    typedef struct packed {
        logic pin_meta;
        logic pin_lvl;
        logic pin_lvl_d;
        logic boot_meta;
        logic boot_lvl;
        logic [16:0] cnt;
        logic [2:0] recent;
    } srs_pin_state_t;
    // sequencer state
    typedef struct packed {
        srs_state_t st;
        logic [15:0] cnt;
        logic clk_en;
        srs_cause_t cause;
        logic seen;
        logic mode_uen;
        logic mode_irq;
        logic [3:0] mode_len;
        logic [31:0] rdata;
        logic [1:0] boot_cnt;
        logic boot_sel;
        logic core_ok_d;
        logic pulse_start;
        logic hold;
    } srs_seq_state_t;
endpackage : srs_pkg

/* File: hdl/srs_reset_sequencer.sv */
// Operation
// - runs on slow clock, drives processor, backup, peripheral and pin resets low.
// - pin is sampled each cycle; a low level requests a user reset.
// - with user reset enable cleared, a low pin causes no reset.
// - status bit shows the sampled pin level at any time.
// - sticky seen flag sets on pin assertion, clears on status read.
// - with irq enable set, pin assertion raises an interrupt instead of reset.
// - pin drive lasts 2^(length+1) cycles; length zero gives two.
// - mode register lives in the backup domain, kept while backup is on.
// - boot select pin is sampled three cycles after core supply rises.
// - reset cause changes only when the processor reset releases; code also loads it if a supply drops on the last clocked cycle.
// - backup power-up passes a fixed startup counter first.
// - then clock on, resets held three cycles, release as general reset.
// - general reset clears mode; pin releases two cycles after backup reset.
// - backup supply low asserts every reset immediately.
// - backup reset releases before core supply can cause other resets.
// - core supply low holds all resets but backup; processor and peripheral assert at once, pin drive from the next cycle.
// - core power-up: resync, clock on three cycles, release as wake-up.
// - after wake-up, pin stays driven for the programmed length.
// - low pin with enable set starts user reset on processor and peripherals.
// - user reset ends after pin rises plus three startup cycles with clock.
// - end of user reset loads cause code four.
// - pin held low externally keeps internal resets until it rises.
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "srs_map.svh"
module srs_reset_sequencer
    import srs_pkg::*;
#(
    parameter int STARTUP_CYCLES = `SRS_STARTUP_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic backup_por_n_in,
    input wire logic core_por_n_in,
    input wire logic pin_reset_in,
    output logic pin_reset_out,
    output logic pin_reset_oe_out,
    input wire logic boot_select_pin_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    output logic proc_reset_n_out,
    output logic backup_reset_n_out,
    output logic periph_reset_n_out,
    output logic ext_drive_n_out,
    output logic proc_clk_en_out,
    output logic user_reset_irq_out,
    output logic boot_select_out
);
    // ------------------------------------------------------------------
    // constants and helpers
    // ------------------------------------------------------------------
    localparam logic [15:0] STARTUP_LAST = 16'(STARTUP_CYCLES - 1);
    localparam logic [15:0] CPU_LAST = `SRS_CPU_START_CYCLES - 16'h0001;

    // true while the backup domain itself is still held
    function automatic logic in_backup(input srs_state_t s);
        in_backup = (s == ST_BK_START) || (s == ST_BK_CLK3);
    endfunction : in_backup

    srs_pin_if bus ();
    srs_seq_state_t r;
    srs_seq_state_t n;
    logic user_trig;
    logic sr_read;
    logic [31:0] sr_value;
    logic [31:0] mr_value;

    // ------------------------------------------------------------------
    // pin manager
    // ------------------------------------------------------------------
    srs_pin_manager u_pin (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in),
        .backup_por_n_in(backup_por_n_in),
        .core_por_n_in(core_por_n_in),
        .pin_reset_in(pin_reset_in),
        .boot_select_pin_in(boot_select_pin_in),
        .bus(bus)
    );

    // ------------------------------------------------------------------
    // register views
    // ------------------------------------------------------------------
    // status and mode words as software reads them
    always_comb begin
        sr_value = 32'h0;
        sr_value[`SRS_SR_SEEN_BIT] = r.seen;
        sr_value[`SRS_SR_CAUSE_LSB +: 3] = r.cause;
        sr_value[`SRS_SR_LEVEL_BIT] = bus.pin_lvl;
        mr_value = 32'h0;
        mr_value[`SRS_MR_UEN_BIT] = r.mode_uen;
        mr_value[`SRS_MR_IRQ_BIT] = r.mode_irq;
        mr_value[`SRS_MR_LEN_LSB +: 4] = r.mode_len;
    end

    // own pulses are masked, else a release pulse would loop into a user reset
    assign user_trig = r.mode_uen & ~r.mode_irq & ~bus.pin_lvl & ~bus.own_recent;
    assign sr_read = reg_rd_in && (reg_addr_in == `SRS_SR_OFFSET);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        n = r;
        n.pulse_start = 1'b0;
        n.rdata = 32'h0;
        n.core_ok_d = bus.core_ok;
        // reset state machine
        case (r.st)
            ST_BK_START: begin
                if (r.cnt == STARTUP_LAST) begin
                    n.st = ST_BK_CLK3;
                    n.cnt = 16'h0;
                    n.clk_en = 1'b1;
                end else begin
                    n.cnt = r.cnt + 16'h1;
                end
            end
            ST_BK_CLK3: begin
                if (r.cnt == CPU_LAST) begin
                    n.st = ST_RUN;
                    n.cause = CAUSE_GENERAL;
                    n.pulse_start = 1'b1;
                end else begin
                    n.cnt = r.cnt + 16'h1;
                end
            end
            ST_RUN: begin
                if (user_trig) begin
                    n.st = ST_USER;
                    n.clk_en = 1'b0;
                    n.pulse_start = 1'b1;
                end
            end
            ST_CORE_DOWN: begin
                if (bus.core_ok) begin
                    n.st = ST_WAKE3;
                    n.cnt = 16'h0;
                    n.clk_en = 1'b1;
                end
            end
            ST_WAKE3: begin
                if (r.cnt == CPU_LAST) begin
                    n.st = ST_RUN;
                    n.cause = CAUSE_WAKE;
                    n.pulse_start = 1'b1;
                end else begin
                    n.cnt = r.cnt + 16'h1;
                end
            end
            ST_USER: begin
                // an outside party may hold the line past our pulse
                if (bus.pin_lvl) begin
                    n.st = ST_USER3;
                    n.cnt = 16'h0;
                    n.clk_en = 1'b1;
                end
            end
            ST_USER3: begin
                if (r.cnt == CPU_LAST) begin
                    n.st = ST_RUN;
                    n.cause = CAUSE_USER;
                    n.pulse_start = 1'b1;
                end else begin
                    n.cnt = r.cnt + 16'h1;
                end
            end
            default: begin
                n.st = ST_BK_START;
            end
        endcase
        // core loss counts only once the backup domain is out of reset
        if (!bus.core_ok && !in_backup(r.st)) begin
            n.st = ST_CORE_DOWN;
            n.clk_en = 1'b0;
            n.pulse_start = 1'b0;
        end
        // backup loss beats everything and wipes the mode register
        if (!bus.bk_ok) begin
            n.st = ST_BK_START;
            n.cnt = 16'h0;
            n.clk_en = 1'b0;
            n.pulse_start = 1'b0;
            n.mode_uen = 1'b0;
            n.mode_irq = 1'b0;
            n.mode_len = `SRS_MR_RESET_LEN;
        end
        n.hold = !(n.st == ST_RUN || n.st == ST_USER || n.st == ST_USER3);
        // boot select sample, counted from the synchronised core edge
        if (bus.core_ok && !r.core_ok_d) begin
            n.boot_cnt = `SRS_BOOT_DELAY;
        end else if (r.boot_cnt != 2'h0) begin
            n.boot_cnt = r.boot_cnt - 2'h1;
            if (r.boot_cnt == 2'h1) begin
                n.boot_sel = bus.boot_lvl;
            end
        end
        // sticky seen flag: a new edge wins over the read that clears it
        if (bus.pin_fall) begin
            n.seen = 1'b1;
        end else if (sr_read) begin
            n.seen = 1'b0;
        end
        // register writes; mode is kept while the backup domain runs
        if (reg_wr_in && reg_addr_in == `SRS_MR_OFFSET && bus.bk_ok) begin
            n.mode_uen = reg_wdata_in[`SRS_MR_UEN_BIT];
            n.mode_irq = reg_wdata_in[`SRS_MR_IRQ_BIT];
            n.mode_len = reg_wdata_in[`SRS_MR_LEN_LSB +: 4];
        end
        // register reads, answer in the following cycle only
        if (reg_rd_in) begin
            if (reg_addr_in == `SRS_SR_OFFSET) begin
                n.rdata = sr_value;
            end else if (reg_addr_in == `SRS_MR_OFFSET) begin
                n.rdata = mr_value;
            end else begin
                n.rdata = 32'h0;
            end
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    // rst_n_in stands for the first backup power-up
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r <= '{st: ST_BK_START, cause: CAUSE_GENERAL, hold: 1'b1, default: '0};
        end else if (clk_en_in) begin
            r <= n;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // supply terms bypass the state machine so assertion is immediate
    assign backup_reset_n_out = !in_backup(r.st) && bus.bk_ok;
    assign proc_reset_n_out = (r.st == ST_RUN) && bus.bk_ok && bus.core_ok;
    assign periph_reset_n_out = (r.st == ST_RUN) && bus.bk_ok && bus.core_ok;
    assign proc_clk_en_out = r.clk_en && bus.bk_ok;
    assign pin_reset_out = 1'b0; // open drain, only pulls low
    assign pin_reset_oe_out = bus.drive_act;
    assign ext_drive_n_out = ~bus.drive_act;
    assign user_reset_irq_out = r.seen & r.mode_irq;
    assign boot_select_out = r.boot_sel;
    assign reg_rdata_out = r.rdata;
    assign bus.pulse_start = r.pulse_start;
    assign bus.pulse_len = r.mode_len;
    assign bus.hold = r.hold;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in || !clk_en_in);

    a_backup_low_all: assert property (!bus.bk_ok |->
        !proc_reset_n_out && !backup_reset_n_out && !periph_reset_n_out && pin_reset_oe_out)
        else $error("backup loss left a reset released");
    a_core_low_hold: assert property (bus.bk_ok && !bus.core_ok |->
        !proc_reset_n_out && !periph_reset_n_out)
        else $error("core loss left processor reset released");
    a_uen_off_quiet: assert property (r.st == ST_RUN && !r.mode_uen && bus.bk_ok
        && bus.core_ok |=> r.st != ST_USER)
        else $error("user reset entered while disabled");
    a_cause_at_release: assert property (r.cause != $past(r.cause) |->
        r.st == ST_RUN && $past(r.st) != ST_RUN)
        else $error("reset cause changed outside a release");
    a_user_cause_four: assert property ($past(r.st) == ST_USER3 && r.st == ST_RUN |->
        r.cause == CAUSE_USER && proc_reset_n_out == bus.core_ok)
        else $error("user reset release did not report code four");
    a_wake_three_cycles: assert property (r.st == ST_CORE_DOWN && bus.core_ok ##1
        bus.core_ok && bus.bk_ok |-> (r.st == ST_WAKE3 && proc_clk_en_out
        && !proc_reset_n_out) [*3] ##1 proc_reset_n_out)
        else $error("wake-up release not three clocked cycles");
    a_seen_set_wins: assert property (bus.pin_fall |=> r.seen)
        else $error("pin edge lost from seen flag");
    a_level_readback: assert property (sr_read |=>
        reg_rdata_out[`SRS_SR_LEVEL_BIT] == $past(bus.pin_lvl))
        else $error("status read shows wrong pin level");
    a_boot_three: assert property ($rose(bus.core_ok) |->
        ##4 (r.boot_sel == $past(bus.boot_lvl)))
        else $error("boot select not sampled three cycles after core rise");
    a_pin_held_user: assert property (r.st == ST_USER && !bus.pin_lvl |=>
        !proc_reset_n_out)
        else $error("processor released while pin still low");

    c_general_release: cover property ($past(r.st) == ST_BK_CLK3 && r.st == ST_RUN);
    c_wake_release: cover property ($past(r.st) == ST_WAKE3 && r.st == ST_RUN);
    c_user_release: cover property ($past(r.st) == ST_USER3 && r.st == ST_RUN);
    c_user_irq: cover property ($rose(user_reset_irq_out));
endmodule : srs_reset_sequencer

/* File: sim/srs_line_partner.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// far-side device sharing the open-drain system reset line
// ----------------------------------------------------------------------
module srs_line_partner (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic go_in,
    input wire logic [7:0] hold_in,
    output logic pull_out
);
    logic [7:0] left_r;
    // hold count: a long span models a slow device that outlasts our own pulse
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            left_r <= 8'h00;
        end else if (go_in) begin
            left_r <= hold_in;
        end else if (left_r != 8'h00) begin
            left_r <= left_r - 8'h01;
        end
    end
    // released line is left to the board pull-up, never to a stale level
    assign pull_out = (left_r != 8'h00);
endmodule : srs_line_partner

/* File: sim/system_reset_sequencer_test.sv */
`timescale 1ns/10ps
`include "srs_map.svh"
module system_reset_sequencer_test
    import srs_pkg::*;
;
    typedef struct {logic [31:0] exp; logic [31:0] mask;} srs_note_t;
    srs_note_t notes[$];
    int error_cnt = 0;
    int cmp_count = 0;
    int n;
    logic clk_in, rst_n_in, bk_por, core_por, boot_pin, wr, rd, go, rd_pend, bsel;
    logic [3:0] addr;
    logic [31:0] wdata, rnd;
    logic [7:0] hold;
    logic pin_do, pin_oe, pull, proc_n, bk_n, per_n, pclk, irq, boot_out, line, ext_n;
    logic [31:0] rdata;
    localparam logic [31:0] CMASK = 32'h0000_0700;
    // ------------------------------------------------------------------
    // design, partner and the resolved reset line (pull-up on the board)
    // ------------------------------------------------------------------
    srs_reset_sequencer #(.STARTUP_CYCLES(4)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .clk_en_in(1'b1), .backup_por_n_in(bk_por), .core_por_n_in(core_por),
        .pin_reset_in(line), .pin_reset_out(pin_do), .pin_reset_oe_out(pin_oe),
        .boot_select_pin_in(boot_pin), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .proc_reset_n_out(proc_n),
        .backup_reset_n_out(bk_n), .periph_reset_n_out(per_n), .ext_drive_n_out(ext_n),
        .proc_clk_en_out(pclk), .user_reset_irq_out(irq), .boot_select_out(boot_out));
    srs_line_partner far (.clk_in(clk_in), .rst_n_in(rst_n_in), .go_in(go), .hold_in(hold),
        .pull_out(pull));
    assign line = pin_oe ? pin_do : (pull ? 1'b0 : 1'b1);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word
    task chk_bit(input string nm, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit
    task wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask : wr_reg
    // the note is queued here; the monitor below compares when data appear
    task rd_reg(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk_in);
        rd <= 1'b1; addr <= a; notes.push_back('{e, m});
        @(posedge clk_in);
        rd <= 1'b0;
    endtask : rd_reg
    task push_line(input logic [7:0] h);
        @(posedge clk_in);
        go <= 1'b1; hold <= h;
        @(posedge clk_in);
        go <= 1'b0;
    endtask : push_line
    task wait_rel(input logic bk);
        n = 0;
        while (((bk ? bk_n : proc_n) !== 1'b1) && n < 500) begin
            n++;
            @(negedge clk_in);
        end
        chk_bit("release seen", 1'b1, n < 500);
    endtask : wait_rel
    // counts cycles of our own pin drive, starting from the current cycle
    task count_oe();
        n = 0;
        while (pin_oe === 1'b1 && n < 300) begin
            n++;
            @(negedge clk_in);
        end
    endtask : count_oe
    task stay_up();
        logic ok;
        ok = 1'b1;
        repeat (12) begin
            @(negedge clk_in);
            ok = ok & proc_n;
        end
        chk_bit("processor reset held off", 1'b1, ok);
    endtask : stay_up
    task close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out
    // ------------------------------------------------------------------
    // clock, result monitor and watchdog
    // ------------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    // read data stand only in the cycle after the strobe, so look there
    always @(negedge clk_in) begin
        if (rd_pend === 1'b1 && notes.size() > 0) begin
            chk_word("read data", notes[0].exp & notes[0].mask, rdata & notes[0].mask);
            void'(notes.pop_front());
        end
        rd_pend = rd;
    end
    initial begin
        #(100 * 4000);
        error_cnt++;
        $display("mismatch watchdog expected done seen timeout");
        close_out();
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_n_in = 1'b0; bk_por = 1'b1; core_por = 1'b1; boot_pin = 1'b0; rd_pend = 1'b0;
        wr = 1'b0; rd = 1'b0; go = 1'b0; addr = 4'h0; wdata = 32'h0; hold = 8'h00;
        rnd = 32'h0000_112e;
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'b1;
        wait_rel(1'b1);
        chk_bit("pin drive strobe at backup release", 1'b0, ext_n);
        chk_bit("processor clock at release", 1'b1, pclk);
        count_oe();
        chk_word("pin drive after general reset", 32'h2, n);
        wait_rel(1'b0);
        rd_reg(`SRS_SR_OFFSET, 32'(CAUSE_GENERAL) << `SRS_SR_CAUSE_LSB, CMASK);
        rd_reg(`SRS_MR_OFFSET, 32'h0, 32'hffff_ffff);
        wr_reg(`SRS_MR_OFFSET, 32'h0000_0201);
        wr_reg(4'hc, 32'hffff_ffff);
        rd_reg(`SRS_MR_OFFSET, 32'h0000_0201, 32'hffff_ffff);
        rd_reg(4'hc, 32'h0, 32'hffff_ffff);
        // wake-up with a random boot strap
        rnd = xs(rnd);
        bsel = rnd[0];
        @(posedge clk_in);
        boot_pin <= bsel; core_por <= 1'b0;
        #1;
        chk_bit("processor reset on core loss", 1'b0, proc_n);
        chk_bit("peripheral reset on core loss", 1'b0, per_n);
        chk_bit("backup reset on core loss", 1'b1, bk_n);
        repeat (5) @(posedge clk_in);
        core_por <= 1'b1;
        wait_rel(1'b0);
        count_oe();
        chk_word("pin drive after wake-up", 32'h1 << (2 + 1), n);
        chk_bit("boot select", bsel, boot_out);
        rd_reg(`SRS_SR_OFFSET, 32'(CAUSE_WAKE) << `SRS_SR_CAUSE_LSB, CMASK);
        rd_reg(`SRS_SR_OFFSET, 32'h0, 32'h0);
        // user reset with the far side holding the line past our pulse
        rnd = xs(rnd);
        push_line(8'd20 + {5'h00, rnd[2:0]});
        repeat (14) @(negedge clk_in);
        chk_bit("processor reset in user reset", 1'b0, proc_n);
        chk_bit("peripheral reset in user reset", 1'b0, per_n);
        rd_reg(`SRS_SR_OFFSET, 32'h0, 32'h0001_0000);
        wait_rel(1'b0);
        count_oe();
        repeat (4) @(posedge clk_in);
        rd_reg(`SRS_SR_OFFSET, (32'(CAUSE_USER) << `SRS_SR_CAUSE_LSB) | 32'h1, CMASK | 32'h1);
        rd_reg(`SRS_SR_OFFSET, 32'h0001_0000, 32'h0001_0001);
        // user reset disabled: flag only
        wr_reg(`SRS_MR_OFFSET, 32'h0000_0200);
        push_line(8'h06);
        stay_up();
        rd_reg(`SRS_SR_OFFSET, 32'h1, 32'h1);
        // interrupt instead of reset
        wr_reg(`SRS_MR_OFFSET, 32'h0000_0211);
        push_line(8'h06);
        stay_up();
        chk_bit("interrupt raised", 1'b1, irq);
        rd_reg(`SRS_SR_OFFSET, 32'h1, 32'h1);
        @(negedge clk_in);
        chk_bit("interrupt cleared by read", 1'b0, irq);
        // backup supply loss
        @(posedge clk_in);
        bk_por <= 1'b0;
        #1;
        chk_bit("backup reset on backup loss", 1'b0, bk_n);
        chk_bit("processor reset on backup loss", 1'b0, proc_n);
        repeat (3) @(posedge clk_in);
        bk_por <= 1'b1;
        wait_rel(1'b0);
        count_oe();
        rd_reg(`SRS_MR_OFFSET, 32'h0, 32'hffff_ffff);
        repeat (3) @(posedge clk_in);
        close_out();
    end
endmodule : system_reset_sequencer_test
